// ===== src/mode_register_config.sv
// Memory side: mode register capture, decode and legality check
`timescale 1ns/1ps
module mode_register_config (
  input wire logic clk_i, // Command clock
  input wire logic rst_i, // Synchronous reset
  mode_link_if.mem link, // Command pins
  output logic [18:0] memory_mode_config_o, // Mode register
  output logic [3:0] row_cycle_clocks_o, // Row cycle time
  output logic [3:0] read_latency_clocks_o, // Read latency
  output logic [3:0] write_latency_clocks_o, // Write latency
  output logic [3:0] wr_rd_row_cycle_o, // Write then read gap
  output logic [3:0] burst_words_count_o, // Burst in words
  output logic address_split_select_o, // Split address mode
  output logic dll_enable_o, // DLL running
  output logic impedance_source_select_o, // External impedance
  output logic on_die_termination_enable_o, // Termination on
  output logic setting_illegal_o, // Reserved or illegal setting
  output logic read_allowed_o, // DLL locked, reads allowed
  output logic access_valid_o, // Read/write address complete
  output logic access_is_write_o, // Access is a write
  output logic [21:0] access_addr_o, // Assembled address
  output logic [2:0] access_bank_o // Bank of the access
);
  typedef enum {IDLE, MODE_SECOND, ACC_SECOND} beat_t;
  beat_t state_reg;
  logic [18:0] mode_reg;
  logic [18:0] mode_next;
  logic [21:0] first_address_beat_reg;
  logic [2:0] bank_reg;
  logic write_reg;
  logic [10:0] lock_cnt_reg;
  logic split;
  logic [2:0] cfg;
  logic [3:0] base_rl;
  logic [3:0] row_c;
  logic reserved;

  // Register bit positions used by the image builder
  localparam int DLL_IDX = mode_cfg_pkg::DLL_BIT;
  localparam int IMP_IDX = mode_cfg_pkg::IMP_BIT;
  localparam int ODT_IDX = mode_cfg_pkg::ODT_BIT;

  // Latency table lookup: row cycle and read latency
  function automatic logic [7:0] lat_lookup(input logic [2:0] code);
    case (code)
      3'h0, 3'h1: lat_lookup = {4'h4, 4'h5};
      3'h2: lat_lookup = {4'h6, 4'h7};
      3'h3: lat_lookup = {4'h8, 4'h9};
      3'h4: lat_lookup = {4'h3, 4'h4};
      3'h5: lat_lookup = {4'h5, 4'h6};
      default: lat_lookup = 8'h00;
    endcase
  endfunction

  // Build a register image from one or two address beats
  function automatic logic [18:0] mode_image(
      input logic [21:0] ax, input logic [21:0] ay, input logic two);
    logic [18:0] m;
    m = ax[18:0];
    if (two) begin
      // Ay3,Ay4 -> M1,M2; Ay9 -> M7; Ay8 ignored
      m[2:1] = ay[4:3];
      m[4:3] = ax[4:3];
      m[DLL_IDX] = ay[9];
      m[IMP_IDX] = ax[8];
      m[ODT_IDX] = ax[9];
      m[5] = ax[5];
      m[18:10] = ax[18:10];
      m[0] = ax[0];
    end
    mode_image = m;
  endfunction

  assign split = mode_reg[mode_cfg_pkg::SPLIT_BIT];
  assign cfg = mode_reg[2:0];
  assign {row_c, base_rl} = lat_lookup(cfg);
  assign reserved = (cfg == 3'h6) || (cfg == 3'h7);

  // Beat sequencing for mode writes and split accesses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= IDLE;
    end else begin
      case (state_reg)
        IDLE: begin
          if (split && link.cmd != mode_cfg_pkg::CMD_NOP) begin
            state_reg <= (link.cmd == mode_cfg_pkg::CMD_MODE_WRITE) ?
                         MODE_SECOND : ACC_SECOND;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  // First beat and bank capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_address_beat_reg <= 22'h000000;
      bank_reg <= 3'h0;
      write_reg <= 1'b0;
    end else if (state_reg == IDLE && link.cmd != mode_cfg_pkg::CMD_NOP) begin
      first_address_beat_reg <= link.addr;
      bank_reg <= link.bank_select;
      write_reg <= (link.cmd == mode_cfg_pkg::CMD_WRITE);
    end
  end

  // Mode register next value
  always_comb begin
    mode_next = mode_reg;
    if (state_reg == IDLE && !split &&
        link.cmd == mode_cfg_pkg::CMD_MODE_WRITE) begin
      mode_next = mode_image(link.addr, 22'h000000, 1'b0);
    end else if (state_reg == MODE_SECOND) begin
      mode_next = mode_image(first_address_beat_reg, link.addr, 1'b1);
    end
  end

  // Mode register storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= mode_cfg_pkg::MODE_RESET;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // DLL lock counter, restarted whenever the DLL is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_cnt_reg <= 11'h000;
    end else if (!mode_reg[DLL_IDX]) begin
      lock_cnt_reg <= 11'h000;
    end else if (lock_cnt_reg != 11'(mode_cfg_pkg::DLL_LOCK_CLOCKS)) begin
      lock_cnt_reg <= lock_cnt_reg + 11'h001;
    end
  end

  // Decoded register outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      row_cycle_clocks_o <= 4'h0;
      read_latency_clocks_o <= 4'h0;
      write_latency_clocks_o <= 4'h0;
      wr_rd_row_cycle_o <= 4'h0;
      burst_words_count_o <= 4'h2;
      setting_illegal_o <= 1'b0;
    end else begin
      row_cycle_clocks_o <= row_c;
      // Split mode adds one clock to both latencies
      read_latency_clocks_o <= base_rl + {3'h0, split};
      write_latency_clocks_o <= base_rl + {3'h0, split} + 4'h1;
      wr_rd_row_cycle_o <= (cfg == 3'h4) ? 4'h4 : row_c;
      case (mode_reg[4:3])
        mode_cfg_pkg::BURST_4: burst_words_count_o <= 4'h4;
        mode_cfg_pkg::BURST_8: burst_words_count_o <= 4'h8;
        default: burst_words_count_o <= 4'h2;
      endcase
      setting_illegal_o <= reserved || (mode_reg[4:3] == 2'h3) ||
        (mode_reg[4:3] == mode_cfg_pkg::BURST_8 &&
         (cfg == 3'h0 || cfg == 3'h1 || cfg == 3'h4)) ||
        (mode_reg[18:10] != 9'h000);
    end
  end

  // Assembled access strobe and address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      access_valid_o <= 1'b0;
      access_is_write_o <= 1'b0;
      access_addr_o <= 22'h000000;
      access_bank_o <= 3'h0;
    end else if (state_reg == ACC_SECOND) begin
      access_valid_o <= 1'b1;
      access_is_write_o <= write_reg;
      access_addr_o <= first_address_beat_reg | link.addr;
      access_bank_o <= bank_reg;
    end else begin
      access_valid_o <= !split && (link.cmd == mode_cfg_pkg::CMD_READ ||
                                   link.cmd == mode_cfg_pkg::CMD_WRITE);
      access_is_write_o <= link.cmd == mode_cfg_pkg::CMD_WRITE;
      access_addr_o <= link.addr;
      access_bank_o <= link.bank_select;
    end
  end

  assign memory_mode_config_o = mode_reg;
  assign address_split_select_o = split;
  assign dll_enable_o = mode_reg[DLL_IDX];
  assign impedance_source_select_o = mode_reg[IMP_IDX];
  assign on_die_termination_enable_o = mode_reg[ODT_IDX];
  assign read_allowed_o =
    lock_cnt_reg == 11'(mode_cfg_pkg::DLL_LOCK_CLOCKS);
endmodule

// ===== shared/mode_cfg_pkg.sv
// Package: mode register layout, command codes and timing constants
package mode_cfg_pkg;
  localparam int MODE_W = 19;
  localparam int ADDR_W = 22;
  localparam int BANK_W = 3;
  localparam int LAT_W = 4;
  // Mode register field positions
  localparam int CFG_LSB = 0;
  localparam int BURST_LSB = 3;
  localparam int SPLIT_BIT = 5;
  localparam int UNUSED_BIT = 6;
  localparam int DLL_BIT = 7;
  localparam int IMP_BIT = 8;
  localparam int ODT_BIT = 9;
  localparam int ZERO_LSB = 10;
  localparam int ZERO_MSB = 18;
  // Controller register offsets on the Wishbone side
  localparam logic [3:0] MODE_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  // Value after reset: every field at its default
  localparam logic [18:0] MODE_RESET = 19'h00000;
  // DLL relock wait before a read
  localparam int DLL_LOCK_CLOCKS = 1024;
  // Mode command interval, in command clocks
  localparam int MODE_CMD_GAP = 6;
  // Burst length codes
  localparam logic [1:0] BURST_2 = 2'h0;
  localparam logic [1:0] BURST_4 = 2'h1;
  localparam logic [1:0] BURST_8 = 2'h2;
  // Command codes on the link
  typedef enum logic [1:0] {
    CMD_NOP,
    CMD_MODE_WRITE,
    CMD_READ,
    CMD_WRITE
  } cmd_t;
endpackage

// ===== shared/mode_link_if.sv
// Interface: command and address pins between controller and memory
`timescale 1ns/1ps
interface mode_link_if;
  mode_cfg_pkg::cmd_t cmd;
  logic [21:0] addr;
  logic [2:0] bank_select;
  modport ctrl (output cmd, output addr, output bank_select);
  modport mem (input cmd, input addr, input bank_select);
endinterface

// ===== src/mode_controller.sv
// Controller side: Wishbone registers issuing mode register writes
`timescale 1ns/1ps
module mode_controller (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  mode_link_if.ctrl link // Command pins
);
  logic wr_take;
  logic [18:0] image_reg;
  logic split_reg;
  logic [1:0] beat_reg;
  logic [10:0] wait_reg;
  logic req;
  logic busy;
  logic [18:0] legal;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write lands at the edge where the master sees ack
  assign wr_take = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  assign busy = beat_reg != 2'h0 || wait_reg != 11'h000;
  // Clear bits 10-18; keep burst 8 off configs 0, 1 and 4
  always_comb begin
    legal = {9'h000, wb_dat_i[9:0]};
    if (legal[4:3] == 2'h2 && (legal[2:0] <= 3'h1 || legal[2:0] == 3'h4))
      legal[4:3] = 2'h1;
  end

  // Wishbone slave: ack one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (wb_adr_i == mode_cfg_pkg::MODE_OFS) ?
                  {13'h0000, image_reg} :
                  (wb_adr_i == mode_cfg_pkg::STAT_OFS) ?
                  {31'h00000000, busy} : 32'h00000000;
    end
  end

  // Capture a write and launch the mode sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      image_reg <= mode_cfg_pkg::MODE_RESET;
      split_reg <= 1'b0;
      beat_reg <= 2'h0;
      wait_reg <= 11'h000;
    end else if (wr_take && wb_adr_i == mode_cfg_pkg::MODE_OFS &&
                 wb_sel_i == 4'hF && !busy) begin
      image_reg <= legal;
      beat_reg <= 2'h1;
    end else if (beat_reg == 2'h1) begin
      // Two beats when split mode currently active
      beat_reg <= split_reg ? 2'h2 : 2'h0;
      split_reg <= image_reg[mode_cfg_pkg::SPLIT_BIT];
      wait_reg <= image_reg[mode_cfg_pkg::DLL_BIT] ?
        11'(mode_cfg_pkg::DLL_LOCK_CLOCKS) :
        11'(mode_cfg_pkg::MODE_CMD_GAP);
    end else if (beat_reg == 2'h2) begin
      beat_reg <= 2'h0;
    end else if (wait_reg != 11'h000) begin
      wait_reg <= wait_reg - 11'h001;
    end
  end

  // Drive pins for each beat
  always_comb begin
    link.cmd = mode_cfg_pkg::CMD_NOP;
    link.addr = 22'h000000;
    link.bank_select = 3'h0;
    if (beat_reg == 2'h1) begin
      link.cmd = mode_cfg_pkg::CMD_MODE_WRITE;
      link.addr = {3'h0, image_reg};
    end else if (beat_reg == 2'h2) begin
      link.addr = {12'h000, image_reg[7], 4'h0, image_reg[2:1], 3'h0};
    end
  end
endmodule

// ===== tb/mode_link_monitor.sv
// Checker: assertions on the command link and the decoded mode outputs
`timescale 1ns/1ps
module mode_link_monitor (
  input wire logic clk_i, // Command clock
  input wire logic rst_i, // Synchronous reset
  input mode_cfg_pkg::cmd_t cmd, // Link command
  input wire logic [21:0] addr, // Link address
  input wire logic [18:0] memory_mode_config_o, // Mode register
  input wire logic [3:0] row_cycle_clocks_o, // Row cycle
  input wire logic [3:0] read_latency_clocks_o, // Read latency
  input wire logic [3:0] write_latency_clocks_o, // Write latency
  input wire logic [3:0] burst_words_count_o, // Burst words
  input wire logic dll_enable_o, // DLL running
  input wire logic read_allowed_o, // Reads allowed
  input wire logic setting_illegal_o // Illegal setting
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [2:0] cfg;
  logic [1:0] bl;
  logic [10:0] lock_cnt;
  // Row cycle per latency code
  function automatic logic [3:0] rc_of(input logic [2:0] c);
    case (c)
      3'h2: rc_of = 4'h6;
      3'h3: rc_of = 4'h8;
      3'h4: rc_of = 4'h3;
      3'h5: rc_of = 4'h5;
      default: rc_of = 4'h4;
    endcase
  endfunction
  // Field views
  assign cfg = memory_mode_config_o[2:0];
  assign bl = memory_mode_config_o[4:3];
  // Clocks spent with the DLL running
  always_ff @(posedge clk_i) begin
    if (rst_i || !dll_enable_o) begin
      lock_cnt <= 11'h000;
    end else if (lock_cnt != 11'h7FF) begin
      lock_cnt <= lock_cnt + 11'h001;
    end
  end
  zero_bits_a: assert property (
    cmd == mode_cfg_pkg::CMD_MODE_WRITE |-> addr[18:10] == 9'h000)
    else $error("Mode write with nonzero high bits");
  capture_a: assert property (
    cmd == mode_cfg_pkg::CMD_MODE_WRITE
    && !memory_mode_config_o[5] |=> memory_mode_config_o == $past(addr[18:0]))
    else $error("Mode register not captured");
  latency_table_a: assert property (
    $stable(memory_mode_config_o) && !$past(rst_i) && cfg < 3'h6
    |-> row_cycle_clocks_o == rc_of(cfg) && read_latency_clocks_o ==
    rc_of(cfg) + 4'h1 + {3'h0, memory_mode_config_o[5]})
    else $error("Latency decode wrong");
  wl_plus_one_a: assert property (
    $stable(memory_mode_config_o) && !$past(rst_i) && !setting_illegal_o
    |-> write_latency_clocks_o == read_latency_clocks_o + 4'h1)
    else $error("Write latency not read latency plus one");
  burst_decode_a: assert property (
    $stable(memory_mode_config_o) && !$past(rst_i) && bl != 2'h3
    |-> burst_words_count_o == (4'h2 << bl))
    else $error("Burst decode wrong");
  illegal_flag_a: assert property (
    $stable(memory_mode_config_o) && !$past(rst_i) |-> setting_illegal_o ==
    (cfg > 3'h5 || bl == 2'h3 || (bl == 2'h2 && (cfg < 3'h2 || cfg == 3'h4))
    || memory_mode_config_o[18:10] != 9'h000))
    else $error("Illegal flag wrong");
  dll_off_a: assert property (
    !memory_mode_config_o[7] && !$past(memory_mode_config_o[7])
    |-> !dll_enable_o && !read_allowed_o)
    else $error("DLL running while switched off");
  lock_early_a: assert property (
    read_allowed_o |-> lock_cnt >= 11'h400)
    else $error("Reads allowed before DLL lock wait");
  lock_late_a: assert property (
    lock_cnt >= 11'h400 |-> read_allowed_o)
    else $error("Reads not allowed after DLL lock wait");
endmodule

// ===== tb/ddr_memory_mode_register_config_tb.sv
// Testbench: controller and memory joined over the command link
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t value mismatch", $time); end end
module ddr_memory_mode_register_config_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] wb_dat_o, q, d, r;
  logic wb_ack_o, split, dll, imp, on_die_termination_enable, illegal, rd_ok;
  logic [18:0] mode_cfg;
  logic [3:0] rc, rl, wl, wrrd, burst;
  logic [15:0] lfsr = 16'h0F75;
  logic [21:0] img;
  logic [21:0] img_q [$];
  logic [2:0] c;
  logic [1:0] b, bx;
  logic [3:0] rc_tab [8] = '{4'h4, 4'h4, 4'h6, 4'h8, 4'h3, 4'h5, 4'h0, 4'h0};
  int fail_count = 0;
  int tests_run = 0;
  int n;
  mode_link_if link_bus ();
  mode_controller u_mode_controller (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .link(link_bus));
  mode_register_config u_mode_register_config (.clk_i(clk_i),
    .rst_i(rst_i), .link(link_bus), .memory_mode_config_o(mode_cfg),
    .row_cycle_clocks_o(rc), .read_latency_clocks_o(rl),
    .write_latency_clocks_o(wl), .wr_rd_row_cycle_o(wrrd),
    .burst_words_count_o(burst), .address_split_select_o(split),
    .dll_enable_o(dll), .impedance_source_select_o(imp),
    .on_die_termination_enable_o(on_die_termination_enable), .setting_illegal_o(illegal),
    .read_allowed_o(rd_ok), .access_valid_o(), .access_is_write_o(),
    .access_addr_o(), .access_bank_o());
  mode_link_monitor u_mode_link_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .cmd(link_bus.cmd), .addr(link_bus.addr), .memory_mode_config_o(mode_cfg),
    .row_cycle_clocks_o(rc), .read_latency_clocks_o(rl),
    .write_latency_clocks_o(wl), .burst_words_count_o(burst),
    .dll_enable_o(dll), .read_allowed_o(rd_ok), .setting_illegal_o(illegal));
  // Clock at 4 ns
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // One classic Wishbone cycle, held until ack
  task wb_cycle(input logic w, input logic [3:0] a, input logic [3:0] s,
    input logic [31:0] wd);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= wd;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Poll status until the mode command and its wait are over
  task wait_idle;
    n = 0;
    do begin
      wb_cycle(1'b0, 4'h4, 4'hF, 32'h00000000);
      n++;
    end while (q[0] !== 1'b0 && n < 600);
    `CHK(q[0], 1'b0)
  endtask
  // Mode write, noting the image expected on the link
  task mode_wr(input logic [31:0] wd, input logic [21:0] ex);
    img_q.push_back(ex);
    wb_cycle(1'b1, 4'h0, 4'hF, wd);
    wait_idle();
    repeat (3) @(posedge clk_i);
  endtask
  task wrap_up;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Link watcher: each mode write against the oldest note
  always @(posedge clk_i) begin
    if (rst_i === 1'b0 && link_bus.cmd === mode_cfg_pkg::CMD_MODE_WRITE) begin
      if (img_q.size() == 0) begin
        fail_count++;
        $display("[ERR] %0t unexpected mode write", $time);
      end else `CHK(link_bus.addr, img_q.pop_front())
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      lfsr = lfsr_next(lfsr);
      r = {lfsr, ~lfsr};
      c = i[2:0];
      b = i[4:3];
      bx = (b == 2'h2 && (c < 3'h2 || c == 3'h4)) ? 2'h1 : b;
      d = {r[31:10], r[9:8], 1'b0, r[6], 1'b0, b, c};
      img = {12'h000, r[9:8], 1'b0, r[6], 1'b0, bx, c};
      mode_wr(d, img);
      wb_cycle(1'b0, 4'h0, 4'hF, 32'h00000000);
      `CHK(q, 32'(img[18:0]))
      `CHK(mode_cfg, img[18:0])
      `CHK(illegal, (c > 3'h5 || bx == 2'h3))
      `CHK(imp, r[8])
      `CHK(on_die_termination_enable, r[9])
      if (c < 3'h6) begin
        `CHK(rc, rc_tab[c])
        `CHK(rl, rc_tab[c] + 4'h1)
        `CHK(wl, rc_tab[c] + 4'h2)
      end
      if (bx != 2'h3) `CHK(burst, 4'h2 << bx)
      if (c == 3'h4) `CHK(wrrd, 4'h4)
    end
    mode_wr(32'h00000022, 22'h000022);
    `CHK(split, 1'b1)
    `CHK(rl, 4'h8)
    `CHK(wl, 4'h9)
    // Two-beat write: config bits 1-2 come from the second beat
    mode_wr(32'h0000002B, 22'h00002B);
    `CHK(mode_cfg, 19'h0002B)
    `CHK(rl, 4'hA)
    `CHK(wl, 4'hB)
    mode_wr(32'h00000000, 22'h000000);
    // Partial lanes are refused, unmapped read answers
    wb_cycle(1'b1, 4'h0, 4'h3, 32'h0000000B);
    wait_idle();
    `CHK(mode_cfg, 19'h00000)
    wb_cycle(1'b0, 4'h8, 4'hF, 32'h00000000);
    `CHK(q, 32'h00000000)
    // DLL on: reads held off for the whole lock wait
    img_q.push_back(22'h000080);
    wb_cycle(1'b1, 4'h0, 4'hF, 32'h00000080);
    repeat (1020) @(posedge clk_i);
    `CHK(rd_ok, 1'b0)
    `CHK(dll, 1'b1)
    wait_idle();
    `CHK(rd_ok, 1'b1)
    mode_wr(32'h00000000, 22'h000000);
    `CHK(dll, 1'b0)
    `CHK(rd_ok, 1'b0)
    `CHK(img_q.size(), 0)
    wrap_up();
  end
endmodule
